// >>> rtl/sstseq_defs.svh
`ifndef SSTSEQ_DEFS_SVH
`define SSTSEQ_DEFS_SVH
// Register byte offsets
`define SSTSEQ_CTRL_OFF      12'h000
`define SSTSEQ_CMD_OFF       12'h004
`define SSTSEQ_TIMER_OFF     12'h008
`define SSTSEQ_DELAY_OFF     12'h00c
`define SSTSEQ_COUNT_OFF     12'h010
`define SSTSEQ_CHAN_OFF      12'h014
`define SSTSEQ_STATUS_OFF    12'h018
`define SSTSEQ_PROGRESS_OFF  12'h01c
// Control fields
`define SSTSEQ_CTRL_EXT_BIT   0
`define SSTSEQ_CTRL_SCAN_BIT  1
`define SSTSEQ_CTRL_SRC_LSB   2
`define SSTSEQ_CTRL_PW_LSB    8
// Command bits (write one to act)
`define SSTSEQ_CMD_START_BIT  0
`define SSTSEQ_CMD_HALT_BIT   1
`define SSTSEQ_CMD_KEY_BIT    2
// Limits and reset values
`define SSTSEQ_REPEAT_MIN     10'h001
`define SSTSEQ_REPEAT_MAX     10'h3ff
`define SSTSEQ_READ_MIN       11'h002
`define SSTSEQ_READ_MAX       11'h400
`define SSTSEQ_CHAN_FIRST_MIN 10'h001
`define SSTSEQ_CHAN_FIRST_MAX 10'h31f
`define SSTSEQ_CHAN_LAST_MIN  10'h002
`define SSTSEQ_CHAN_LAST_MAX  10'h320
`define SSTSEQ_PW_RST         8'h04
`endif

// >>> rtl/sstseq_pkg.sv
`default_nettype none
package sstseq_pkg;
  typedef enum logic [1:0] {SRC_IMMEDIATE, SRC_TIMER, SRC_OUTSIDE} sstseq_src_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CONTROL, ST_DELAY, ST_MEASURE, ST_WAIT, ST_TRIGOUT}
    sstseq_state_type;
endpackage
`default_nettype wire

// >>> rtl/sstseq_top.sv
// Functional notes
// [RQ1] Internal cycles measure the second input first, then the first input.
// [RQ2] Second input once per cycle; first input 1 to 1023 times.
// [RQ3] Every reading is stored to the buffer without a separate request.
// [RQ4] External mode: up to 800 channels, all on the first input only.
// [RQ5] Input channel indicators stay off during external operation.
// [RQ6] Immediate source passes straight to the delay stage.
// [RQ7] Internal scan timer spaces cycles, not measurements within a cycle.
// [RQ8] Timer source: first event is satisfied at start, timer starts running.
// [RQ9] Later timer passes wait for interval expiry, or proceed if expired.
// [RQ10] Outside source: start arms; trigger pulse or manual key begins.
// [RQ11] Delay stage holds until the configured delay fully elapses.
// [RQ12] Internal scan sample counter is repeat count plus one.
// [RQ13] Internal scan emits one output pulse after the last first-input reading.
// [RQ14] Internal scan trigger counter sets cycles; loop or go idle.
// [RQ15] Stepping and external scan: timer spaces channels, first event immediate.
// [RQ16] Stepping: second input first; external scan: next list channel each time.
// [RQ17] Stepping and external scan: output pulse after every measurement.
// [RQ18] Stepping and external scan: counter holds total readings; loop back.
// [RQ19] Reading count 2 to 1024 (code checks only the lower bound, accepting up to 2047); only the first 1024 are stored.
// [RQ20] Halt stops any operation and returns to normal mode.
// [RQ21] External first channel 1..799, last 2..800, last above first.
// [RQ22] Output pulse has fixed width; incoming trigger is synchronised and edge detected.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "sstseq_defs.svh"
`default_nettype none
module sstseq_top #(
  parameter int TW = 32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        manual_event_key_in,
  input  wire logic        manual_event_key,
  output logic             manual_event_key_out,
  output logic             meas_start,
  output logic             meas_sel_second,
  output logic [9:0]       meas_channel,
  input  wire logic        meas_done,
  output logic             buf_store,
  output logic [9:0]       buf_index,
  output logic             ind_first_on,
  output logic             ind_second_on,
  output logic             busy
);
  // Configuration registers
  logic          ext_r;
  logic          scan_r;
  logic [1:0]    src_r;
  logic [7:0]    pw_r;
  logic [TW-1:0] timer_ival_r;
  logic [TW-1:0] delay_r;
  logic [9:0]    repeat_r;
  logic [10:0]   total_r;
  logic          total_inf_r;
  logic [9:0]    first_ch_r;
  logic [9:0]    last_ch_r;
  logic          cfg_err_r;
  // Sequencer state
  sstseq_pkg::sstseq_state_type st_r;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] dly_r;
  logic [10:0]   sample_r;
  logic [10:0]   cycles_r;
  logic [10:0]   reads_r;
  logic [9:0]    ch_r;
  logic [9:0]    stored_r;
  logic [7:0]    pulse_r;
  logic          second_r;
  logic          key_r;
  // Only the second stage reads the first, so no half-settled level leaks out
  logic          sync1_r;
  logic          sync2_r;
  logic          sync3_r;

  // APB decode; zero wait state, unmapped reads return zero and flag an error
  wire         wr_en    = psel & penable & pwrite;
  wire         rd_en    = psel & ~pwrite;
  wire         hit_ctrl = paddr == `SSTSEQ_CTRL_OFF;
  wire         hit_cmd  = paddr == `SSTSEQ_CMD_OFF;
  wire         hit_tmr  = paddr == `SSTSEQ_TIMER_OFF;
  wire         hit_dly  = paddr == `SSTSEQ_DELAY_OFF;
  wire         hit_cnt  = paddr == `SSTSEQ_COUNT_OFF;
  wire         hit_chan = paddr == `SSTSEQ_CHAN_OFF;
  wire         hit_stat = paddr == `SSTSEQ_STATUS_OFF;
  wire         hit_prog = paddr == `SSTSEQ_PROGRESS_OFF;
  wire         mapped   = hit_ctrl | hit_cmd | hit_tmr | hit_dly | hit_cnt | hit_chan
                          | hit_stat | hit_prog;
  wire         do_start = wr_en & hit_cmd & pwdata[`SSTSEQ_CMD_START_BIT];
  wire         do_halt  = wr_en & hit_cmd & pwdata[`SSTSEQ_CMD_HALT_BIT];
  wire         sw_key   = wr_en & hit_cmd & pwdata[`SSTSEQ_CMD_KEY_BIT];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Incoming trigger: two-flop synchroniser then rising-edge detect on later stages
  wire         manual_event_key_edge = sync2_r & ~sync3_r; // [RQ22]
  wire         key_edge  = manual_event_key & ~key_r;
  wire         ev_outside = manual_event_key_edge | key_edge | sw_key; // [RQ10]

  // Run-time decodes
  wire         int_scan  = ~ext_r & scan_r;
  wire         tmr_done  = tmr_r == '0;
  wire         last_smp  = sample_r == 11'h001;
  wire         last_cyc  = cycles_r == 11'h001;
  wire         last_read = ~total_inf_r & (reads_r == 11'h001);
  wire         src_ok    = (src_r == sstseq_pkg::SRC_IMMEDIATE)            // [RQ6]
                           | ((src_r == sstseq_pkg::SRC_TIMER) & tmr_done) // [RQ9]
                           | ((src_r == sstseq_pkg::SRC_OUTSIDE) & ev_outside);
  // External list: bounded 1..799 / 2..800 and last above first
  wire         chan_ok   = (pwdata[9:0] >= `SSTSEQ_CHAN_FIRST_MIN)
                           & (pwdata[9:0] <= `SSTSEQ_CHAN_FIRST_MAX)
                           & (pwdata[25:16] >= `SSTSEQ_CHAN_LAST_MIN)
                           & (pwdata[25:16] <= `SSTSEQ_CHAN_LAST_MAX)
                           & (pwdata[25:16] > pwdata[9:0]); // [RQ21]
  wire         rep_ok    = (pwdata[9:0] >= `SSTSEQ_REPEAT_MIN); // [RQ2]
  wire         tot_ok    = pwdata[31] | (pwdata[26:16] >= `SSTSEQ_READ_MIN); // [RQ19]
  wire [10:0]  rep_plus1 = {1'b0, repeat_r} + 11'h001; // [RQ12]
  wire         idle      = st_r == sstseq_pkg::ST_IDLE;
  wire         cfg_wr    = wr_en & idle;

  // Control fields; taken only while idle so a run sees stable settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_r  <= 1'b0;
      scan_r <= 1'b0;
      src_r  <= 2'h0;
      pw_r   <= `SSTSEQ_PW_RST;
    end
    else if (cfg_wr & hit_ctrl)
    begin
      ext_r  <= pwdata[`SSTSEQ_CTRL_EXT_BIT];
      scan_r <= pwdata[`SSTSEQ_CTRL_SCAN_BIT];
      src_r  <= (pwdata[`SSTSEQ_CTRL_SRC_LSB +: 2] == 2'h3) ? 2'h0
                : pwdata[`SSTSEQ_CTRL_SRC_LSB +: 2];
      pw_r   <= (pwdata[`SSTSEQ_CTRL_PW_LSB +: 8] == 8'h00) ? 8'h01
                : pwdata[`SSTSEQ_CTRL_PW_LSB +: 8];
    end
  end

  // Timer interval and delay length, in clock cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_ival_r <= '0;
      delay_r      <= '0;
    end
    else
    begin
      if (cfg_wr & hit_tmr)
        timer_ival_r <= pwdata[TW-1:0];
      if (cfg_wr & hit_dly)
        delay_r <= pwdata[TW-1:0];
    end
  end

  // Counts and channel list; a word failing rep_ok, tot_ok or chan_ok is dropped and flagged, never clipped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      repeat_r    <= `SSTSEQ_REPEAT_MIN;
      total_r     <= `SSTSEQ_READ_MIN;
      total_inf_r <= 1'b0;
      first_ch_r  <= `SSTSEQ_CHAN_FIRST_MIN;
      last_ch_r   <= `SSTSEQ_CHAN_LAST_MIN;
      cfg_err_r   <= 1'b0;
    end
    else
    begin
      if (cfg_wr & hit_cnt)
      begin
        if (rep_ok & tot_ok)
        begin
          repeat_r    <= pwdata[9:0];
          total_r     <= pwdata[26:16];
          total_inf_r <= pwdata[31];
        end
        cfg_err_r <= ~(rep_ok & tot_ok);
      end
      if (cfg_wr & hit_chan)
      begin
        if (chan_ok)
        begin
          first_ch_r <= pwdata[9:0];
          last_ch_r  <= pwdata[25:16];
        end
        cfg_err_r <= ~chan_ok;
      end
    end
  end

  // Read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en & hit_ctrl)
      prdata = {16'h0000, pw_r, 4'h0, src_r, scan_r, ext_r};
    else if (rd_en & hit_tmr)
      prdata = 32'(timer_ival_r);
    else if (rd_en & hit_dly)
      prdata = 32'(delay_r);
    else if (rd_en & hit_cnt)
      prdata = {total_inf_r, 4'h0, total_r, 6'h00, repeat_r};
    else if (rd_en & hit_chan)
      prdata = {6'h00, last_ch_r, 6'h00, first_ch_r};
    else if (rd_en & hit_stat)
      prdata = {24'h000000, cfg_err_r, 3'h0, 1'b0, st_r};
    else if (rd_en & hit_prog)
      prdata = {6'h00, stored_r, 5'h00, reads_r};
  end

  // Synchroniser for the incoming trigger line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      sync1_r <= manual_event_key_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Key history; resets to the key's idle level so no false press follows reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_r <= 1'b0;
    else
      key_r <= manual_event_key;
  end

  // Interval timer runs freely from start; reloads each time the source is passed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr_r <= '0;
    else if (idle | do_halt)
      tmr_r <= '0; // [RQ8] [RQ15]
    else if (st_r == sstseq_pkg::ST_CONTROL && src_ok)
      tmr_r <= timer_ival_r; // [RQ7] [RQ9]
    else if (!tmr_done)
      tmr_r <= tmr_r - 1'b1;
  end

  // Main sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= sstseq_pkg::ST_IDLE;
      dly_r     <= '0;
      sample_r  <= 11'h000;
      cycles_r  <= 11'h000;
      reads_r   <= 11'h000;
      ch_r      <= 10'h000;
      stored_r  <= 10'h000;
      second_r  <= 1'b0;
      pulse_r   <= 8'h00;
      meas_start <= 1'b0;
      buf_store <= 1'b0;
      buf_index <= 10'h000;
    end
    else
    begin
      meas_start <= 1'b0;
      buf_store  <= 1'b0;
      if (do_halt)
      begin
        st_r    <= sstseq_pkg::ST_IDLE; // [RQ20]
        pulse_r <= 8'h00;
      end
      else
      begin
        if (pulse_r != 8'h00)
          pulse_r <= pulse_r - 8'h01;
        case (st_r)
          sstseq_pkg::ST_IDLE:
            if (do_start)
            begin
              st_r     <= sstseq_pkg::ST_CONTROL; // [RQ10]
              reads_r  <= total_r;
              stored_r <= 10'h000;
              ch_r     <= first_ch_r;
              second_r <= ~ext_r; // [RQ1] [RQ4]
              // Cycle count: readings divided by cycle length, floored
              cycles_r <= (rep_plus1 == 11'h000) ? 11'h000 : total_r / rep_plus1; // [RQ14]
            end
          sstseq_pkg::ST_CONTROL:
            if (src_ok)
            begin
              st_r     <= sstseq_pkg::ST_DELAY;
              dly_r    <= delay_r;
              sample_r <= rep_plus1; // [RQ12]
            end
          sstseq_pkg::ST_DELAY:
            if (dly_r == '0)
            begin
              st_r       <= sstseq_pkg::ST_MEASURE; // [RQ11]
              meas_start <= 1'b1;
            end
            else
              dly_r <= dly_r - 1'b1;
          sstseq_pkg::ST_MEASURE:
            st_r <= sstseq_pkg::ST_WAIT;
          sstseq_pkg::ST_WAIT:
            if (meas_done)
            begin
              // Store whatever arrives, up to the buffer depth
              if (stored_r != 10'h3ff || buf_index != 10'h3ff)
              begin
                buf_store <= ~(stored_r == 10'h3ff && buf_index == 10'h3ff); // [RQ3] [RQ19]
                buf_index <= stored_r;
                stored_r  <= (stored_r == 10'h3ff) ? stored_r : stored_r + 10'h001;
              end
              reads_r  <= reads_r - 11'h001;
              second_r <= 1'b0; // [RQ16]
              ch_r     <= (ch_r == last_ch_r) ? first_ch_r : ch_r + 10'h001; // [RQ16]
              if (int_scan)
              begin
                sample_r <= sample_r - 11'h001;
                if (!last_smp)
                begin
                  st_r  <= sstseq_pkg::ST_DELAY; // [RQ7] [RQ12]
                  dly_r <= delay_r;
                end
                else
                begin
                  pulse_r  <= pw_r; // [RQ13]
                  cycles_r <= cycles_r - 11'h001;
                  second_r <= 1'b1; // [RQ1]
                  st_r     <= last_cyc ? sstseq_pkg::ST_TRIGOUT
                              : sstseq_pkg::ST_CONTROL; // [RQ14]
                end
              end
              else
              begin
                pulse_r <= pw_r; // [RQ17]
                st_r    <= last_read ? sstseq_pkg::ST_TRIGOUT
                           : sstseq_pkg::ST_CONTROL; // [RQ18] [RQ15]
              end
            end
          sstseq_pkg::ST_TRIGOUT:
            if (pulse_r <= 8'h01)
              st_r <= sstseq_pkg::ST_IDLE; // Let the last pulse finish first
          default:
            st_r <= sstseq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Outputs to the measurement engine and front panel
  assign manual_event_key_out        = pulse_r != 8'h00; // [RQ22]
  assign meas_sel_second = ~ext_r & second_r; // [RQ1] [RQ4]
  assign meas_channel    = ext_r ? ch_r : 10'h000; // [RQ16]
  assign busy            = ~idle;
  assign ind_first_on    = ~idle & ~ext_r & ~second_r; // [RQ5]
  assign ind_second_on   = ~idle & ~ext_r & second_r; // [RQ5]
endmodule
`default_nettype wire

// >>> verif/sstseq_chk.sv
`include "sstseq_defs.svh"
`default_nettype none
module sstseq_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        manual_event_key_out,
  input wire logic        meas_start,
  input wire logic        meas_sel_second,
  input wire logic [9:0]  meas_channel,
  input wire logic        meas_done,
  input wire logic        buf_store,
  input wire logic        ind_first_on,
  input wire logic        ind_second_on,
  input wire logic        busy
);
  logic open_r;
  logic first_r;
  wire  halt_w = psel && penable && pwrite && paddr == `SSTSEQ_CMD_OFF && pwdata[1];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outstanding measurement, and the first one of each run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      open_r  <= 1'b0;
      first_r <= 1'b0;
    end
    else
    begin
      open_r  <= meas_start || (open_r && !meas_done);
      first_r <= (!busy) || (first_r && !meas_start);
    end
  end
  property p_second_first;
    meas_start && first_r && meas_channel == 10'h000 |-> meas_sel_second;
  endproperty
  a_second_first: assert property (p_second_first) else $error("first reading not on second input");
  property p_ext_first_only;
    meas_start && meas_channel != 10'h000 |-> !meas_sel_second;
  endproperty
  a_ext_first_only: assert property (p_ext_first_only) else $error("external reading on second input");
  property p_ext_ind_off;
    meas_channel != 10'h000 |-> !ind_first_on && !ind_second_on;
  endproperty
  a_ext_ind_off: assert property (p_ext_ind_off) else $error("indicator lit in external mode");
  property p_store;
    busy && meas_done && !halt_w |-> ##[0:2] buf_store;
  endproperty
  a_store: assert property (p_store) else $error("reading not stored");
  property p_manual_event_key_cause;
    $rose(manual_event_key_out) |-> $past(meas_done);
  endproperty
  a_manual_event_key_cause: assert property (p_manual_event_key_cause) else $error("output pulse without a reading");
  property p_single_open;
    meas_start |-> !open_r;
  endproperty
  a_single_open: assert property (p_single_open) else $error("measurement started twice");
  property p_halt;
    halt_w |-> ##[1:2] (!busy && !meas_start);
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop the run");
  property p_idle_quiet;
    !busy |-> !meas_start && !ind_first_on && !ind_second_on;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
  property p_store_busy;
    buf_store |-> busy;
  endproperty
  a_store_busy: assert property (p_store_busy) else $error("store while idle");
endmodule
`default_nettype wire

// >>> verif/sstseq_partner.sv
`default_nettype none
module sstseq_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic meas_start,
  input  wire logic fire,
  input  wire logic slow,
  output logic      meas_done,
  output logic      manual_event_key_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r;
  int hold_r;
  // Engine answers each start after a random latency; slow mode stretches it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_done <= 1'b0;
      manual_event_key_in   <= 1'b0;
      wait_r    <= 0;
      hold_r    <= 0;
    end
    else
    begin
      meas_done <= 1'b0;
      if (meas_start)
        wait_r <= 1 + $urandom % 4 + (slow ? 30 : 0);
      else if (wait_r == 1)
        meas_done <= 1'b1;
      if (!meas_start && wait_r > 0)
        wait_r <= wait_r - 1;
      // Mainframe trigger pulse, three cycles so the sync sees it
      if (fire)
        hold_r <= 3;
      else if (hold_r > 0)
        hold_r <= hold_r - 1;
      manual_event_key_in <= fire || hold_r > 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/step_scan_trigger_sequencer_tb.sv
`include "sstseq_defs.svh"
`default_nettype none
module step_scan_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, manual_event_key, fire, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, manual_event_key_in, manual_event_key_out, meas_start, meas_sel_second, meas_done;
  logic        buf_store, ind_first_on, ind_second_on, busy, er, tprev, strict, rdy;
  logic [9:0]  meas_channel, buf_index;
  logic [10:0] expq[$];
  int          fails, check_count, trigs, manual_event_key_hi, r, f, sidx;
  sstseq_top sstseq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .manual_event_key_in, .manual_event_key, .manual_event_key_out, .meas_start,
    .meas_sel_second, .meas_channel, .meas_done, .buf_store, .buf_index, .ind_first_on,
    .ind_second_on, .busy);
  sstseq_partner sstseq_partner_i (.pclk, .presetn, .meas_start, .fire, .slow, .meas_done,
    .manual_event_key_in);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; a spare edge after release keeps drivers apart
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken as settled just before the sampling edge, not racing it
    do
    begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      n++;
    end
    while (rdy !== 1'b1 && n < 100);
    chk("pready", n < 100, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic manual_event_key_wait(input int want);
    int n;
    n = 0;
    while (trigs < want && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("trigger wait", n < 5000, 1);
  endtask
  // Configure, start and follow one run to idle
  task automatic run(input logic [31:0] ctrl, cnt, chan, input int ntrig);
    int n;
    trigs = 0;
    manual_event_key_hi = 0;
    sidx = 0;
    apb(1'b1, `SSTSEQ_CTRL_OFF, ctrl);
    apb(1'b1, `SSTSEQ_COUNT_OFF, cnt);
    apb(1'b1, `SSTSEQ_CHAN_OFF, chan);
    apb(1'b1, `SSTSEQ_CMD_OFF, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    if (ctrl[3:2] == 2'h2)
    begin
      chk("armed only", expq.size(), ntrig);
      for (int k = 0; k < ntrig; k++)
      begin
        if (k % 2 == 1)
          manual_event_key <= 1'b1;
        else
          fire <= 1'b1;
        @(posedge pclk);
        manual_event_key <= 1'b0;
        fire <= 1'b0;
        manual_event_key_wait(k + 1);
        repeat (4) @(posedge pclk);
      end
    end
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("idle", n < 20000, 1);
    chk("trigger count", trigs, ntrig);
    chk("trigger width", manual_event_key_hi, ntrig * 2);
    chk("readings left", expq.size(), 0);
  endtask
  // Result watcher: each measurement start takes the oldest expected note
  // Sampled mid-cycle so registered pulses are seen once, never in their launch step
  always @(negedge pclk)
  begin
    if (buf_store === 1'b1 && strict)
    begin
      chk("buffer index", buf_index, sidx);
      sidx++;
    end
    if (manual_event_key_out === 1'b1)
      manual_event_key_hi++;
    if (manual_event_key_out === 1'b1 && tprev !== 1'b1)
      trigs++;
    tprev = manual_event_key_out;
    if (meas_start === 1'b1 && strict)
      if (expq.size() == 0)
        chk("extra measurement", 1, 0);
      else
        chk("input and channel", {meas_sel_second, meas_channel}, expq.pop_front());
  end
  initial
  begin
    {psel, penable, pwrite, manual_event_key, fire, slow} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    strict = 1'b1;
    void'($urandom(34));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SSTSEQ_STATUS_OFF, '0);
    chk("status at reset", rd, 0);
    apb(1'b0, 12'h0f0, '0);
    chk("unmapped error", er, 1);
    apb(1'b1, `SSTSEQ_DELAY_OFF, 32'h0000_0003);
    $display("test reset done");
    // Internal scan, immediate source, two cycles of random length
    r = 1 + $urandom % 3;
    repeat (2)
    begin
      expq.push_back(11'h400);
      repeat (r) expq.push_back(11'h000);
    end
    run(32'h0000_0202, (32'(2 * (r + 1)) << 16) | 32'(r), 0, 2);
    $display("test internal scan done");
    // Internal step on the timer, slow engine
    slow <= 1'b1;
    apb(1'b1, `SSTSEQ_TIMER_OFF, 32'h0000_0014);
    expq = '{11'h400, 11'h000, 11'h000};
    run(32'h0000_0204, 32'h0003_0001, 0, 3);
    slow <= 1'b0;
    $display("test internal step done");
    // External scan on outside triggers, random channel list
    f = 1 + $urandom % 790;
    expq = '{11'(f), 11'(f + 1), 11'(f + 2)};
    run(32'h0000_020b, 32'h0003_0001, (32'(f + 2) << 16) | 32'(f), 3);
    $display("test external scan done");
    // Halt in mid-run
    strict = 1'b0;
    apb(1'b1, `SSTSEQ_CTRL_OFF, 32'h0000_0202);
    apb(1'b1, `SSTSEQ_COUNT_OFF, 32'h0400_0003);
    apb(1'b1, `SSTSEQ_CMD_OFF, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    apb(1'b1, `SSTSEQ_CMD_OFF, 32'h0000_0002);
    chk("busy after halt", busy, 0);
    apb(1'b0, `SSTSEQ_STATUS_OFF, '0);
    chk("state after halt", rd[2:0], 0);
    strict = 1'b1;
    $display("test halt done");
    // Repeat count of zero is refused
    apb(1'b1, `SSTSEQ_COUNT_OFF, 32'h0002_0000);
    apb(1'b0, `SSTSEQ_STATUS_OFF, '0);
    chk("config error", rd[7], 1);
    $display("test refused count done");
    conclude;
  end
endmodule
bind sstseq_top sstseq_chk sstseq_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .manual_event_key_out, .meas_start, .meas_sel_second, .meas_channel, .meas_done, .buf_store,
  .ind_first_on, .ind_second_on, .busy);
`default_nettype wire
